// file: hdl/pmg_param_gateway.sv
// Parameter memory gateway: burst access, keyed burn, burn counter and completion flags.
//
// Functional notes
// [R1] Burst writes are accepted whatever the operating mode.
// [R2] Host moves parameter memory only in whole blocks of eight bytes.
// [R3] Host opens a burst write with enable field 01 and direction 0.
// [R4] Host then writes a base address that is a multiple of eight.
// [R5] Write direction: byte at index i is stored at base plus i.
// [R6] Host closes every burst by writing 000 into config bits 5:3.
// [R7] Full memory takes sixteen bursts, bases 0x00 to 0x78.
// [R8] Host waits for the interrupt, or 30 ms in sleep, between bursts.
// [R9] Applied burst write in active or doze sets flag bit 5 and interrupt.
// [R10] In sleep a burst write completes silently, without the interrupt.
// [R11] Reading the interrupt source clears bit 5 and releases the interrupt.
// [R12] Burst reads are served whatever the operating mode.
// [R13] Host opens a burst read with enable 01 and direction 1.
// [R14] Read direction: indices 0 to 7 return bytes from base onward.
// [R15] Host burns at most three times, only with complete memory contents.
// [R16] Host burns only in active or doze mode.
// [R17] Finished burn sets flag bit 6 and asserts the interrupt.
// [R18] After reset the memory is loaded from burned contents when valid.
// [R19] Burn count is readable in bits 2:0 of the store status register.
// [R20] As shipped the count is zero and factory defaults are used.
// [R21] Each burn counts up; the fourth reverts to factory defaults for good.
// [R22] Burn unlock: 0x62 to key high, then 0x9d to key low.
// [R23] Then 0xa5 and 0x5a to the base register trigger the burn.
// [R24] Config register at 0x0d; enable field accepts only 00 and 01.
// [R25] Burn key registers sit at 0xac and 0xad.
// [R26] Mode codes: 00 active, 01 doze, 10 sleep, 11 reserved.
// [R27] Burn arms only on the exact four-write order; any deviation abandons it.
// [R28] With the gateway off, addresses 0 to 7 keep their normal meaning.
`timescale 1ns/1ps
module pmg_param_gateway #(
	parameter logic [7:0] FACTORY_SEED = 8'h3c
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic lclk_in,
	input wire logic acc_valid_in,
	input pmg_pkg::pmg_acc_s acc_req_in,
	output logic acc_ready_out,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	input wire logic [1:0] mode_in,
	input wire logic factory_init_in,
	output logic fwd_valid_out,
	output pmg_pkg::pmg_acc_s fwd_req_out,
	input wire logic [7:0] fwd_rdata_in,
	input wire logic [6:0] spm_rd_addr_in,
	output logic [7:0] spm_rd_data_out,
	output logic [2:0] burn_counter_out,
	output logic burned_contents_valid_out,
	output logic busy_out,
	output logic irq_out_n
);
	import pmg_pkg::*;

	pmg_acc_s link_req;
	logic link_tgl;
	logic rq_s1_ff;
	logic rq_s2_ff;
	logic rq_s3_ff;
	logic pend_ff;
	logic stage_ff;
	logic ack_tgl_ff;
	logic [7:0] ack_data_ff;
	logic [7:0] local_rdata_ff;
	logic use_fwd_ff;
	logic overlay_ff;
	logic [7:0] gateway_config_ff;
	logic [7:0] burst_base_address_ff;
	logic burst_dirty_ff;
	logic irq_wr_ff;
	logic irq_burn_ff;
	logic [2:0] burn_counter_ff;
	logic burned_contents_valid_ff;
	pmg_key_e key_ff;
	pmg_key_e nxt_key;
	pmg_core_e core_ff;
	logic [6:0] copy_idx_ff;
	logic [7:0] shadow_param_memory [PMG_SPM_DEPTH];
	logic [7:0] nvm_mem [PMG_SPM_DEPTH];

	logic serve;
	logic is_wr;
	logic in_window;
	logic gw_on;
	logic gw_read_dir;
	logic [6:0] spm_idx;
	logic spm_host_wr;
	logic cfg_wr;
	logic base_wr;
	logic key_trigger_wr;
	logic burn_go;
	logic wr_apply;
	logic irq_clr;
	logic use_nvm;
	logic burn_done;
	logic [2:0] nxt_count;

	pmg_link u_link (
		.lclk_in(lclk_in),
		.rst_in(rst_in),
		.acc_valid_in(acc_valid_in),
		.acc_req_in(acc_req_in),
		.acc_ready_out(acc_ready_out),
		.rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out),
		.req_out(link_req),
		.req_tgl_out(link_tgl),
		.ack_tgl_in(ack_tgl_ff),
		.ack_data_in(ack_data_ff)
	);

	// Request toggle crosses into the core clock; the third stage only detects the change.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rq_s1_ff <= 1'b0;
			rq_s2_ff <= 1'b0;
			rq_s3_ff <= 1'b0;
		end else begin
			rq_s1_ff <= link_tgl;
			rq_s2_ff <= rq_s1_ff;
			rq_s3_ff <= rq_s2_ff;
		end
	end

	// Accesses wait while the memory is being loaded or burned.
	assign serve = pend_ff && !stage_ff && (core_ff == PMG_CORE_IDLE);
	assign is_wr = link_req.write;
	assign gw_on = gateway_config_ff[PMG_GW_EN_LSB +: 2] == PMG_GW_EN_ON;
	assign gw_read_dir = gateway_config_ff[PMG_GW_DIR_BIT];
	assign in_window = link_req.addr <= PMG_ADDR_WIN_LAST;
	assign spm_idx = pmg_spm_index(burst_base_address_ff, link_req.addr);
	assign spm_host_wr = serve && is_wr && in_window && gw_on && !gw_read_dir; // [R1] [R5]
	assign cfg_wr = serve && is_wr && (link_req.addr == PMG_ADDR_GW_CFG); // [R24]
	assign key_trigger_wr = ((key_ff == PMG_KEY_LO) && (link_req.wdata == PMG_TRIG1_VAL))
		|| ((key_ff == PMG_KEY_TRIG1) && (link_req.wdata == PMG_TRIG2_VAL));
	assign base_wr = serve && is_wr && (link_req.addr == PMG_ADDR_BASE) && !key_trigger_wr;
	assign irq_clr = serve && !is_wr && (link_req.addr == PMG_ADDR_IRQ_SRC) && !gw_on; // [R11]
	assign use_nvm = burned_contents_valid_ff && (burn_counter_ff != PMG_COUNT_FRESH)
		&& (burn_counter_ff <= PMG_COUNT_LAST_OK); // [R18] [R20]
	assign burn_done = (core_ff == PMG_CORE_BURN) && (copy_idx_ff == PMG_IDX_LAST);
	assign nxt_count = (burn_counter_ff == PMG_COUNT_DEAD) ? PMG_COUNT_DEAD
		: burn_counter_ff + 3'h1; // [R21]

	// Closing a write burst that stored data is the point where the write is applied.
	assign wr_apply = cfg_wr && gw_on && !gw_read_dir && burst_dirty_ff
		&& (link_req.wdata[PMG_GW_EN_LSB +: 2] == PMG_GW_EN_OFF)
		&& (pmg_mode_e'(mode_in) != PMG_MODE_SLEEP); // [R9] [R10] [R26]

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_ff <= 1'b0;
		end else if (rq_s2_ff != rq_s3_ff) begin
			pend_ff <= 1'b1;
		end else if (serve) begin
			pend_ff <= 1'b0;
		end
	end

	// Stage 0 decodes and issues, stage 1 captures the read data and answers the link.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			stage_ff <= 1'b0;
			ack_tgl_ff <= 1'b0;
			ack_data_ff <= 8'h00;
			use_fwd_ff <= 1'b0;
			overlay_ff <= 1'b0;
			fwd_valid_out <= 1'b0;
			fwd_req_out <= '0;
		end else begin
			fwd_valid_out <= 1'b0;
			if (serve) begin
				stage_ff <= 1'b1;
				use_fwd_ff <= 1'b0;
				overlay_ff <= 1'b0;
				if (!(in_window && gw_on)
					&& (link_req.addr != PMG_ADDR_STATUS)
					&& (link_req.addr != PMG_ADDR_GW_CFG)
					&& (link_req.addr != PMG_ADDR_BASE)
					&& (link_req.addr != PMG_ADDR_KEY_HI)
					&& (link_req.addr != PMG_ADDR_KEY_LO)) begin // [R28]
					fwd_valid_out <= 1'b1;
					fwd_req_out <= link_req;
					use_fwd_ff <= 1'b1;
					overlay_ff <= !is_wr && (link_req.addr == PMG_ADDR_IRQ_SRC);
				end
			end else if (stage_ff) begin
				stage_ff <= 1'b0;
				ack_tgl_ff <= ~ack_tgl_ff;
				if (!use_fwd_ff) begin
					ack_data_ff <= local_rdata_ff;
				end else if (overlay_ff) begin
					ack_data_ff <= fwd_rdata_in;
					ack_data_ff[PMG_IRQ_WR_BIT] <= local_rdata_ff[PMG_IRQ_WR_BIT];
					ack_data_ff[PMG_IRQ_BURN_BIT] <= local_rdata_ff[PMG_IRQ_BURN_BIT];
				end else begin
					ack_data_ff <= fwd_rdata_in;
				end
			end
		end
	end

	// Local read data, taken in stage 0 so that clear-on-read sees the flags before clearing.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			local_rdata_ff <= 8'h00;
		end else if (serve) begin
			local_rdata_ff <= 8'h00;
			if (in_window && gw_on && gw_read_dir) begin
				local_rdata_ff <= shadow_param_memory[spm_idx]; // [R12] [R14]
			end else if (in_window && gw_on) begin
				local_rdata_ff <= 8'h00;
			end else if (link_req.addr == PMG_ADDR_GW_CFG) begin
				local_rdata_ff <= gateway_config_ff;
			end else if (link_req.addr == PMG_ADDR_BASE) begin
				local_rdata_ff <= burst_base_address_ff;
			end else if (link_req.addr == PMG_ADDR_STATUS) begin
				local_rdata_ff[2:0] <= burn_counter_ff; // [R19]
				local_rdata_ff[PMG_STAT_VALID_BIT] <= use_nvm;
			end else if (link_req.addr == PMG_ADDR_IRQ_SRC) begin
				local_rdata_ff[PMG_IRQ_WR_BIT] <= irq_wr_ff;
				local_rdata_ff[PMG_IRQ_BURN_BIT] <= irq_burn_ff;
			end
		end
	end

	// Enable codes 10 and 11 are refused; the direction bit is still taken.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			gateway_config_ff <= PMG_GW_CFG_RST;
		end else if (cfg_wr) begin
			gateway_config_ff[PMG_GW_DIR_BIT] <= link_req.wdata[PMG_GW_DIR_BIT];
			if (link_req.wdata[PMG_GW_EN_LSB + 1] == 1'b0) begin
				gateway_config_ff[PMG_GW_EN_LSB +: 2] <= link_req.wdata[PMG_GW_EN_LSB +: 2]; // [R24]
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			burst_base_address_ff <= PMG_BASE_RST;
		end else if (base_wr) begin
			burst_base_address_ff <= link_req.wdata;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			burst_dirty_ff <= 1'b0;
		end else if (spm_host_wr) begin
			burst_dirty_ff <= 1'b1;
		end else if (cfg_wr && (link_req.wdata[PMG_GW_EN_LSB +: 2] == PMG_GW_EN_OFF)) begin
			burst_dirty_ff <= 1'b0;
		end
	end

	// A new event in the cycle of a clearing read wins over the clear.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_wr_ff <= 1'b0;
			irq_burn_ff <= 1'b0;
			irq_out_n <= 1'b1;
		end else begin
			irq_wr_ff <= wr_apply | (irq_wr_ff & ~irq_clr); // [R9] [R11]
			irq_burn_ff <= burn_done | (irq_burn_ff & ~irq_clr); // [R17]
			irq_out_n <= ~(wr_apply | burn_done
				| ((irq_wr_ff | irq_burn_ff) & ~irq_clr)); // [R9] [R11] [R17]
		end
	end

	// Every write, to any address, advances or abandons the burn unlock sequence.
	always_comb begin
		nxt_key = PMG_KEY_IDLE;
		case (key_ff)
			PMG_KEY_IDLE: begin
				if ((link_req.addr == PMG_ADDR_KEY_HI) && (link_req.wdata == PMG_KEY_HI_VAL)) begin
					nxt_key = PMG_KEY_HI; // [R22] [R25]
				end
			end
			PMG_KEY_HI: begin
				if ((link_req.addr == PMG_ADDR_KEY_LO) && (link_req.wdata == PMG_KEY_LO_VAL)) begin
					nxt_key = PMG_KEY_LO; // [R22] [R25]
				end
			end
			PMG_KEY_LO: begin
				if ((link_req.addr == PMG_ADDR_BASE) && (link_req.wdata == PMG_TRIG1_VAL)) begin
					nxt_key = PMG_KEY_TRIG1; // [R23]
				end
			end
			default: begin
				nxt_key = PMG_KEY_IDLE;
			end
		endcase
		if (!link_req.stop) begin
			nxt_key = PMG_KEY_IDLE; // [R27]
		end
	end

	assign burn_go = serve && is_wr && link_req.stop && (key_ff == PMG_KEY_TRIG1)
		&& (link_req.addr == PMG_ADDR_BASE) && (link_req.wdata == PMG_TRIG2_VAL); // [R23] [R27]

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			key_ff <= PMG_KEY_IDLE;
		end else if (serve && is_wr) begin
			key_ff <= nxt_key; // [R27]
		end
	end

	// Loader after reset and burn engine both walk the memory one byte per cycle.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			core_ff <= PMG_CORE_LOAD;
			copy_idx_ff <= 7'h00;
		end else begin
			case (core_ff)
				PMG_CORE_LOAD: begin
					copy_idx_ff <= copy_idx_ff + 7'h01;
					if (copy_idx_ff == PMG_IDX_LAST) begin
						core_ff <= PMG_CORE_IDLE; // [R18]
					end
				end
				PMG_CORE_IDLE: begin
					copy_idx_ff <= 7'h00;
					if (burn_go) begin
						core_ff <= PMG_CORE_BURN;
					end
				end
				PMG_CORE_BURN: begin
					copy_idx_ff <= copy_idx_ff + 7'h01;
					if (copy_idx_ff == PMG_IDX_LAST) begin
						core_ff <= PMG_CORE_IDLE;
					end
				end
				default: begin
					core_ff <= PMG_CORE_IDLE;
					copy_idx_ff <= 7'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (core_ff == PMG_CORE_LOAD) begin
			if (use_nvm) begin
				shadow_param_memory[copy_idx_ff] <= nvm_mem[copy_idx_ff]; // [R18]
			end else begin
				shadow_param_memory[copy_idx_ff] <= FACTORY_SEED ^ {1'b0, copy_idx_ff}; // [R20]
			end
		end else if (spm_host_wr) begin
			shadow_param_memory[spm_idx] <= link_req.wdata; // [R5]
		end
	end

	// Once the count has passed three the stored copy is never written again.
	always_ff @(posedge mclk_in) begin
		if ((core_ff == PMG_CORE_BURN) && (burn_counter_ff < PMG_COUNT_DEAD)) begin
			nvm_mem[copy_idx_ff] <= shadow_param_memory[copy_idx_ff];
		end
	end

	// Non-volatile state survives resets; only the factory preparation clears it.
	always_ff @(posedge mclk_in) begin
		if (factory_init_in) begin
			burn_counter_ff <= PMG_COUNT_FRESH; // [R20]
			burned_contents_valid_ff <= 1'b0;
		end else if (burn_done) begin
			burn_counter_ff <= nxt_count; // [R21]
			burned_contents_valid_ff <= nxt_count <= PMG_COUNT_LAST_OK; // [R21]
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			burn_counter_out <= PMG_COUNT_FRESH;
			burned_contents_valid_out <= 1'b0;
			busy_out <= 1'b1;
			spm_rd_data_out <= 8'h00;
		end else begin
			burn_counter_out <= burn_counter_ff; // [R19]
			burned_contents_valid_out <= use_nvm;
			busy_out <= core_ff != PMG_CORE_IDLE;
			spm_rd_data_out <= shadow_param_memory[spm_rd_addr_in];
		end
	end
endmodule // pmg_param_gateway

// file: hdl/pmg_pkg.sv
// Shared constants, types and helpers of the parameter memory gateway.
package pmg_pkg;
	localparam int unsigned PMG_DW = 8;
	localparam int unsigned PMG_SPM_DEPTH = 128;
	localparam int unsigned PMG_SPM_AW = 7;
	localparam int unsigned PMG_BURST_LEN = 8;

	localparam logic [7:0] PMG_ADDR_IRQ_SRC = 8'h00;
	localparam logic [7:0] PMG_ADDR_WIN_LAST = 8'h07;
	localparam logic [7:0] PMG_ADDR_STATUS = 8'h08;
	localparam logic [7:0] PMG_ADDR_GW_CFG = 8'h0d;
	localparam logic [7:0] PMG_ADDR_BASE = 8'h0e;
	localparam logic [7:0] PMG_ADDR_KEY_HI = 8'hac;
	localparam logic [7:0] PMG_ADDR_KEY_LO = 8'had;

	localparam logic [7:0] PMG_KEY_HI_VAL = 8'h62;
	localparam logic [7:0] PMG_KEY_LO_VAL = 8'h9d;
	localparam logic [7:0] PMG_TRIG1_VAL = 8'ha5;
	localparam logic [7:0] PMG_TRIG2_VAL = 8'h5a;

	localparam int unsigned PMG_GW_EN_LSB = 4;
	localparam int unsigned PMG_GW_DIR_BIT = 3;
	localparam logic [1:0] PMG_GW_EN_OFF = 2'h0;
	localparam logic [1:0] PMG_GW_EN_ON = 2'h1;
	localparam int unsigned PMG_IRQ_WR_BIT = 5;
	localparam int unsigned PMG_IRQ_BURN_BIT = 6;
	localparam int unsigned PMG_STAT_VALID_BIT = 3;

	localparam logic [7:0] PMG_GW_CFG_RST = 8'h00;
	localparam logic [7:0] PMG_BASE_RST = 8'h00;
	localparam logic [2:0] PMG_COUNT_FRESH = 3'h0;
	localparam logic [2:0] PMG_COUNT_LAST_OK = 3'h3;
	localparam logic [2:0] PMG_COUNT_DEAD = 3'h4;
	localparam logic [6:0] PMG_IDX_LAST = 7'h7f;

	typedef enum logic [1:0] {
		PMG_MODE_ACTIVE = 2'b00,
		PMG_MODE_DOZE = 2'b01,
		PMG_MODE_SLEEP = 2'b10,
		PMG_MODE_RSVD = 2'b11
	} pmg_mode_e;

	typedef enum logic [1:0] {
		PMG_KEY_IDLE = 2'b00,
		PMG_KEY_HI = 2'b01,
		PMG_KEY_LO = 2'b10,
		PMG_KEY_TRIG1 = 2'b11
	} pmg_key_e;

	typedef enum logic [1:0] {
		PMG_CORE_LOAD = 2'b00,
		PMG_CORE_IDLE = 2'b01,
		PMG_CORE_BURN = 2'b10
	} pmg_core_e;

	// One register access as handed over by the serial front end.
	typedef struct packed {
		logic write;
		logic stop;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmg_acc_s;

	// Memory location of a burst byte: base address plus register index.
	function automatic logic [6:0] pmg_spm_index(input logic [7:0] base, input logic [7:0] addr);
		logic [7:0] sum;
		sum = base + {5'h00, addr[2:0]};
		return sum[6:0];
	endfunction
endpackage

// file: hdl/pmg_link.sv
// Link-clock end: takes register accesses and hands them to the core by toggle handshake.
`timescale 1ns/1ps
module pmg_link (
	input wire logic lclk_in,
	input wire logic rst_in,
	input wire logic acc_valid_in,
	input pmg_pkg::pmg_acc_s acc_req_in,
	output logic acc_ready_out,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	output pmg_pkg::pmg_acc_s req_out,
	output logic req_tgl_out,
	input wire logic ack_tgl_in,
	input wire logic [7:0] ack_data_in
);
	import pmg_pkg::*;

	logic ack_s1_ff;
	logic ack_s2_ff;
	logic busy_ff;

	always_ff @(posedge lclk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end else begin
			ack_s1_ff <= ack_tgl_in;
			ack_s2_ff <= ack_s1_ff;
		end
	end

	// The request word is held until the core answers, so the core may sample it freely.
	always_ff @(posedge lclk_in or posedge rst_in) begin
		if (rst_in) begin
			req_out <= '0;
			req_tgl_out <= 1'b0;
			busy_ff <= 1'b0;
			acc_ready_out <= 1'b0;
			rd_valid_out <= 1'b0;
			rd_data_out <= 8'h00;
		end else begin
			rd_valid_out <= 1'b0;
			if (!busy_ff && acc_ready_out && acc_valid_in) begin
				req_out <= acc_req_in;
				req_tgl_out <= ~req_tgl_out;
				busy_ff <= 1'b1;
				acc_ready_out <= 1'b0;
			end else if (busy_ff && (ack_s2_ff == req_tgl_out)) begin
				busy_ff <= 1'b0;
				acc_ready_out <= 1'b1;
				rd_valid_out <= ~req_out.write;
				rd_data_out <= ack_data_in;
			end else if (!busy_ff) begin
				acc_ready_out <= 1'b1;
			end
		end
	end
endmodule // pmg_link

// file: testbench/pmg_gw_sva.sv
// Assertions and covers on the ports of the parameter memory gateway.
`timescale 1ns/1ps
module pmg_gw_sva (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic lclk_in,
	input wire logic acc_valid_in,
	input wire logic acc_ready_out,
	input wire logic rd_valid_out,
	input wire logic fwd_valid_out,
	input pmg_pkg::pmg_acc_s fwd_req_out,
	input wire logic factory_init_in,
	input wire logic [2:0] burn_counter_out,
	input wire logic burned_contents_valid_out,
	input wire logic busy_out,
	input wire logic irq_out_n
);
	import pmg_pkg::*;
	logic [1:0] up_ff;
	logic [7:0] busy_len_ff;
	// Counter values seen in the first edges after reset are the reset image, not a burn.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			up_ff <= 2'h0;
		end else if (up_ff != 2'h3) begin
			up_ff <= up_ff + 2'h1;
		end
	end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_len_ff <= 8'h00;
		end else if (!busy_out) begin
			busy_len_ff <= 8'h00;
		end else if (busy_len_ff != 8'hff) begin
			busy_len_ff <= busy_len_ff + 8'h01;
		end
	end
	a_fwd_one_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
		fwd_valid_out |=> !fwd_valid_out) else $error("forward strobe longer than one cycle");
	a_irq_read_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		fwd_valid_out && !fwd_req_out.write && fwd_req_out.addr == PMG_ADDR_IRQ_SRC
		|-> ##[1:3] irq_out_n) else $error("interrupt not released by source read");
	a_count_max: assert property (@(posedge mclk_in) disable iff (rst_in)
		burn_counter_out <= PMG_COUNT_DEAD) else $error("burn counter beyond four");
	a_valid_count: assert property (@(posedge mclk_in) disable iff (rst_in)
		burned_contents_valid_out |-> burn_counter_out inside {[3'h1:3'h3]})
		else $error("stored copy in use with bad count");
	a_count_step: assert property (@(posedge mclk_in) disable iff (rst_in)
		up_ff == 2'h3 && !$past(factory_init_in) && $changed(burn_counter_out)
		|-> burn_counter_out == $past(burn_counter_out) + 3'h1 && $past(busy_out))
		else $error("burn counter moved without a burn");
	a_burn_irq: assert property (@(posedge mclk_in) disable iff (rst_in)
		up_ff == 2'h3 && !$past(factory_init_in) && $changed(burn_counter_out)
		|-> ##[0:2] !irq_out_n) else $error("no interrupt after burn");
	a_busy_min: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(busy_out) |-> busy_out[*8]) else $error("burn ended too soon");
	a_busy_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
		busy_len_ff <= 8'h8c) else $error("busy held too long");
	a_take_drop: assert property (@(posedge lclk_in) disable iff (rst_in)
		acc_valid_in && acc_ready_out |=> !acc_ready_out) else $error("ready kept after take");
	a_rd_answer: assert property (@(posedge lclk_in) disable iff (rst_in)
		rd_valid_out |-> acc_ready_out ##1 !rd_valid_out) else $error("bad read answer");
	a_ready_back: assert property (@(posedge lclk_in) disable iff (rst_in)
		$fell(acc_ready_out) |-> ##[1:60] acc_ready_out) else $error("access never answered");
	c_irq: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(irq_out_n));
	c_burn: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(busy_out));
	c_read: cover property (@(posedge lclk_in) disable iff (rst_in) rd_valid_out);
endmodule // pmg_gw_sva

bind pmg_param_gateway pmg_gw_sva u_sva (.mclk_in(mclk_in), .rst_in(rst_in),
	.lclk_in(lclk_in), .acc_valid_in(acc_valid_in), .acc_ready_out(acc_ready_out),
	.rd_valid_out(rd_valid_out), .fwd_valid_out(fwd_valid_out), .fwd_req_out(fwd_req_out),
	.factory_init_in(factory_init_in), .burn_counter_out(burn_counter_out),
	.burned_contents_valid_out(burned_contents_valid_out), .busy_out(busy_out),
	.irq_out_n(irq_out_n));

// file: testbench/pmg_host_model.sv
// Host master model: register accesses, burst sequences and the burn sequence.
`timescale 1ns/1ps
module pmg_host_model (
	input wire logic lclk_in,
	input wire logic acc_ready_in,
	input wire logic rd_valid_in,
	input wire logic [7:0] rd_data_in,
	output logic acc_valid_out,
	output pmg_pkg::pmg_acc_s acc_req_out
);
	import pmg_pkg::*;
	int gap = 0;
	int hangs = 0;
	initial begin
		acc_valid_out = 1'b0;
		acc_req_out = '0;
	end
	// Request held until taken; released lines show the inverse of the last value.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		q = 8'h00;
		repeat (gap + 1) @(posedge lclk_in);
		acc_valid_out <= 1'b1;
		acc_req_out <= '{write: w, stop: 1'b1, addr: a, wdata: d};
		n = 0;
		do begin
			@(posedge lclk_in);
			n++;
		end while (!acc_ready_in && n < 400);
		acc_valid_out <= 1'b0;
		acc_req_out <= pmg_acc_s'(~acc_req_out);
		do begin
			@(posedge lclk_in);
			n++;
		end while (!acc_ready_in && n < 800);
		if (rd_valid_in) q = rd_data_in;
		if (n >= 800) hangs++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic burst_wr(input logic [7:0] base, input logic [7:0] d0);
		wr(PMG_ADDR_GW_CFG, 8'h10);
		wr(PMG_ADDR_BASE, base);
		for (int i = 0; i < 8; i++)
			wr(8'(i), d0 + 8'(i));
		wr(PMG_ADDR_GW_CFG, 8'h00);
	endtask
	task automatic burst_rd(input logic [7:0] base, output logic [7:0] q [8]);
		wr(PMG_ADDR_GW_CFG, 8'h18);
		wr(PMG_ADDR_BASE, base);
		for (int i = 0; i < 8; i++)
			acc(1'b0, 8'(i), 8'h00, q[i]);
		wr(PMG_ADDR_GW_CFG, 8'h00);
	endtask
	task automatic burn(input logic [7:0] key_hi);
		wr(PMG_ADDR_KEY_HI, key_hi);
		wr(PMG_ADDR_KEY_LO, PMG_KEY_LO_VAL);
		wr(PMG_ADDR_BASE, PMG_TRIG1_VAL);
		wr(PMG_ADDR_BASE, PMG_TRIG2_VAL);
	endtask
endmodule // pmg_host_model

// file: testbench/pmg_param_gateway_tb_top.sv
// Self-checking bench of the parameter memory gateway.
`timescale 1ns/1ps
module pmg_param_gateway_tb_top;
	import pmg_pkg::*;
	localparam logic [7:0] SEED = 8'h5e;
	logic mclk_in = 1'b0;
	logic lclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic acc_valid, acc_ready, rd_valid, fwd_valid, valid_nv, busy, irq_n;
	pmg_acc_s acc_req, fwd_req;
	logic [7:0] rd_data, fwd_rdata, spm_data, r;
	logic [1:0] mode = 2'h0;
	// Held for the first two core clock edges of the opening reset so the stored count is known before any check runs.
	logic factory_init = 1'b1;
	logic [6:0] spm_addr = 7'h00;
	logic [2:0] count;
	logic [7:0] q [8];
	int err_total = 0;
	int comparisons = 0;
	always #2.5 mclk_in = ~mclk_in;
	initial begin
		#7;
		forever #16 lclk_in = ~lclk_in;
	end
	// The rest of the register file answers with the inverted address.
	assign fwd_rdata = ~fwd_req.addr;
	pmg_param_gateway #(.FACTORY_SEED(SEED)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.lclk_in(lclk_in), .acc_valid_in(acc_valid), .acc_req_in(acc_req),
		.acc_ready_out(acc_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.mode_in(mode), .factory_init_in(factory_init), .fwd_valid_out(fwd_valid),
		.fwd_req_out(fwd_req), .fwd_rdata_in(fwd_rdata), .spm_rd_addr_in(spm_addr),
		.spm_rd_data_out(spm_data), .burn_counter_out(count),
		.burned_contents_valid_out(valid_nv), .busy_out(busy), .irq_out_n(irq_n));
	pmg_host_model host (.lclk_in(lclk_in), .acc_ready_in(acc_ready), .rd_valid_in(rd_valid),
		.rd_data_in(rd_data), .acc_valid_out(acc_valid), .acc_req_out(acc_req));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		host.acc(1'b0, a, 8'h00, r);
		chk(what, exp, r);
	endtask
	task automatic settle();
		int n;
		repeat (4) @(posedge mclk_in);
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge mclk_in);
			n++;
		end
		if (n >= 2000) err_total++;
	endtask
	task automatic do_reset();
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (12) @(posedge mclk_in);
		repeat (2) @(posedge lclk_in);
		@(posedge mclk_in);
		rst_in <= 1'b0;
		settle();
	endtask
	task automatic wait_irq(input logic exp_low);
		int n;
		n = 0;
		while (irq_n !== 1'b0 && n < 40) begin
			@(posedge mclk_in);
			n++;
		end
		chk("irq_out_n", {7'h00, !exp_low}, {7'h00, irq_n});
	endtask
	task automatic final_report();
		err_total += host.hangs;
		$display("Checks made %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk_in);
		err_total++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge mclk_in);
		factory_init <= 1'b0;
		do_reset();
		rd(PMG_ADDR_STATUS, 8'h00, "shipped status");
		host.burst_rd(8'h00, q);
		for (int i = 0; i < 8; i++)
			chk("factory byte", SEED ^ 8'(i), q[i]);
		for (int m = 0; m < 4; m++) begin
			@(posedge mclk_in);
			mode <= 2'(m);
			host.burst_wr(8'h40 + 8'(8 * m), 8'(16 * m));
			wait_irq(m != 2);
			rd(PMG_ADDR_IRQ_SRC, (m != 2) ? 8'hbf : 8'h9f, "irq source");
			chk("irq released", 8'h01, {7'h00, irq_n});
		end
		@(posedge mclk_in);
		mode <= PMG_MODE_SLEEP;
		host.burst_rd(8'h50, q);
		for (int i = 0; i < 8; i++)
			chk("sleep read", 8'h20 + 8'(i), q[i]);
		@(posedge mclk_in);
		spm_addr <= 7'h53;
		repeat (2) @(posedge mclk_in);
		chk("spm port", 8'h23, spm_data);
		host.wr(PMG_ADDR_GW_CFG, 8'h28);
		rd(PMG_ADDR_GW_CFG, 8'h08, "refused enable");
		rd(8'h03, 8'hfc, "window off");
		@(posedge mclk_in);
		mode <= PMG_MODE_ACTIVE;
		host.gap = 3;
		for (int b = 0; b < 16; b++) begin
			host.burst_wr(8'(8 * b), 8'(8 * b) ^ 8'h5a);
			wait_irq(1'b1);
			rd(PMG_ADDR_IRQ_SRC, 8'hbf, "irq source");
		end
		host.gap = 0;
		host.burn(8'h26);
		settle();
		chk("count kept", 8'h00, {5'h00, count});
		for (int k = 1; k <= 4; k++) begin
			host.burn(PMG_KEY_HI_VAL);
			settle();
			wait_irq(1'b1);
			rd(PMG_ADDR_IRQ_SRC, 8'hdf, "burn flag");
			rd(PMG_ADDR_STATUS, {4'h0, k <= 3, 3'(k)}, "status");
			chk("valid out", {7'h00, k <= 3}, {7'h00, valid_nv});
			if (k == 1) begin
				do_reset();
				host.burst_rd(8'h30, q);
				for (int i = 0; i < 8; i++)
					chk("burned byte", 8'h6a + 8'(i), q[i]);
			end
		end
		do_reset();
		host.burst_rd(8'h00, q);
		for (int i = 0; i < 8; i++)
			chk("default byte", SEED ^ 8'(i), q[i]);
		final_report();
	end
endmodule // pmg_param_gateway_tb_top
